// ---- shared/flash_seq_params.svh ----
// Constants of the flash page program sequencer: offsets, fields, resets, counts
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define OFS_CTRL 4'h0
`define OFS_CMD 4'h4
`define OFS_STATUS 4'h8
`define BIT_READY 0
`define BIT_LOCK_VIOLATION_FLAG 2
`define BIT_PROGRAMMING_ERROR_FLAG 3
`define CMD_KEY 8'ha5
`define CMD_WRITE_PAGE 6'h01
`define CMD_CLEAR_PB 6'h03
`define CMD_ERASE_ALL 6'h08
`define CMD_QUICK_CHECK 6'h0c
`define WS_PB_WRITE 3'h4
`define WS_FLASH_READ 3'h2
`define PB_WORDS 64
`define PB_LAST 6'h3f
`define RST_CTRL 2'h0
`endif

// ---- shared/flash_seq_pkg.sv ----
// Types of the flash page program sequencer
package flash_seq_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_PEND = 3'h1,
        S_PROG = 3'h3,
        S_VOLCLR = 3'h2,
        S_ERASE = 3'h6,
        S_FINISH = 3'h4
    } state_t;
    typedef struct packed {
        logic lock_ie;
        logic ready_ie;
    } ctrl_t;
    typedef struct packed {
        logic programming_error_flag;
        logic lock_violation_flag;
        logic ready;
    } status_t;
endpackage : flash_seq_pkg

// ---- rtl/flash_page_program_sequencer.sv ----
// Flash command sequencer with write-only one-page buffer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_params.svh"
module flash_page_program_sequencer #(
    parameter int PAGE_BITS = 10
) (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic HSB_VALID_IN,
    input wire logic HSB_WRITE_IN,
    input wire logic [PAGE_BITS+5:0] HSB_ADDR_IN,
    input wire logic [31:0] HSB_WDATA_IN,
    input wire logic HSB_SECURE_IN,
    output logic HSB_READY_OUT,
    output logic [31:0] HSB_RDATA_OUT,
    output logic [PAGE_BITS+5:0] FLASH_RD_ADDR_OUT,
    input wire logic [31:0] FLASH_RD_DATA_IN,
    output logic FLASH_WR_EN_OUT,
    output logic [PAGE_BITS-1:0] FLASH_WR_PAGE_OUT,
    output logic [5:0] FLASH_WR_INDEX_OUT,
    output logic [31:0] FLASH_WR_DATA_OUT,
    output logic FLASH_ERASE_ALL_OUT,
    output logic VOLATILE_CLEAR_REQ_OUT,
    input wire logic VOLATILE_CLEAR_DONE_IN,
    input wire logic [15:0] LOCK_FUSES_IN,
    input wire logic [2:0] BOOT_AREA_PROTECT_FUSES_IN,
    input wire logic [15:0] SECURE_REGIONS_IN,
    output logic IRQ_OUT
);
    // Region of a page: the top four page bits select one of sixteen
    function automatic logic [3:0] region_of(input logic [PAGE_BITS-1:0] pg);
        region_of = pg[PAGE_BITS-1 -: 4];
    endfunction : region_of

    // Boot area covers the lowest 2**n pages for a non-zero setting
    function automatic logic in_boot_area(input logic [PAGE_BITS-1:0] pg,
                                          input logic [2:0] bp);
        logic [PAGE_BITS:0] limit;
        limit = (PAGE_BITS+1)'(1) << bp;
        in_boot_area = (bp != 3'h0) && ({1'b0, pg} < limit);
    endfunction : in_boot_area

    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    flash_seq_pkg::state_t state;
    flash_seq_pkg::state_t next_state;
    flash_seq_pkg::ctrl_t flash_control_reg;
    flash_seq_pkg::status_t flags;
    logic [31:0] page_buffer [`PB_WORDS];
    logic [PAGE_BITS-1:0] target_page_number;
    logic [5:0] pend_cmd;
    logic pb_secure;
    logic [5:0] prog_idx;
    logic [2:0] hsb_cnt;
    logic done_event;
    logic av_ack;
    logic [31:0] read_mux;

    // Register bus decode
    wire av_req = AVS_READ_IN | AVS_WRITE_IN;
    wire av_take = av_req & av_ack;
    wire cmd_wr = av_take & AVS_WRITE_IN & (AVS_ADDRESS_IN == `OFS_CMD);
    wire ctrl_wr = av_take & AVS_WRITE_IN & (AVS_ADDRESS_IN == `OFS_CTRL);
    wire status_rd = av_take & AVS_READ_IN & (AVS_ADDRESS_IN == `OFS_STATUS);
    wire [5:0] wr_code = AVS_WRITEDATA_IN[5:0];
    wire key_ok = AVS_WRITEDATA_IN[31:24] == `CMD_KEY;
    wire code_ok = (wr_code == `CMD_WRITE_PAGE) | (wr_code == `CMD_CLEAR_PB)
                 | (wr_code == `CMD_ERASE_ALL) | (wr_code == `CMD_QUICK_CHECK);
    wire cmd_accept = cmd_wr & (state == flash_seq_pkg::S_IDLE) & key_ok & code_ok;

    // High-speed bus decode; a single port serialises all accesses
    wire busy = (state != flash_seq_pkg::S_IDLE) & (state != flash_seq_pkg::S_PEND);
    wire hsb_idle = ~HSB_VALID_IN & (hsb_cnt == 3'h0);
    wire pb_fire = HSB_VALID_IN & HSB_WRITE_IN & ~busy & (hsb_cnt == `WS_PB_WRITE);
    wire rd_fire = HSB_VALID_IN & ~HSB_WRITE_IN & ~busy & (hsb_cnt == `WS_FLASH_READ);
    wire [5:0] pb_idx = HSB_ADDR_IN[5:0];
    wire [PAGE_BITS-1:0] pb_page = HSB_ADDR_IN[PAGE_BITS+5:6];
    assign HSB_READY_OUT = pb_fire | rd_fire;

    // Protection checks for the pending command
    wire [3:0] tgt_region = region_of(target_page_number);
    wire page_locked = ~LOCK_FUSES_IN[tgt_region]
                     | in_boot_area(target_page_number, BOOT_AREA_PROTECT_FUSES_IN);
    wire secure_hit = SECURE_REGIONS_IN[tgt_region] & ~pb_secure;
    wire any_lock = (LOCK_FUSES_IN != 16'hffff) | (BOOT_AREA_PROTECT_FUSES_IN != 3'h0);
    wire start = (state == flash_seq_pkg::S_PEND) & hsb_idle;
    wire lock_refuse = start & (((pend_cmd == `CMD_WRITE_PAGE) & (page_locked | secure_hit))
                     | ((pend_cmd == `CMD_ERASE_ALL) & any_lock));
    wire programming_error_flag_set = cmd_wr & ~cmd_accept;
    wire done_set = (state == flash_seq_pkg::S_FINISH) & (pend_cmd != `CMD_QUICK_CHECK);

    always_comb begin
        next_state = state;
        case (state)
            flash_seq_pkg::S_IDLE: begin
                if (cmd_wr) begin
                    next_state = cmd_accept ? flash_seq_pkg::S_PEND : flash_seq_pkg::S_FINISH;
                end
            end
            flash_seq_pkg::S_PEND: begin
                if (start) begin
                    if (lock_refuse) begin
                        next_state = flash_seq_pkg::S_FINISH;
                    end else if (pend_cmd == `CMD_WRITE_PAGE) begin
                        next_state = flash_seq_pkg::S_PROG;
                    end else if (pend_cmd == `CMD_ERASE_ALL) begin
                        next_state = flash_seq_pkg::S_VOLCLR;
                    end else begin
                        next_state = flash_seq_pkg::S_FINISH;
                    end
                end
            end
            flash_seq_pkg::S_PROG: begin
                if (prog_idx == `PB_LAST) begin
                    next_state = flash_seq_pkg::S_FINISH;
                end
            end
            flash_seq_pkg::S_VOLCLR: begin
                if (VOLATILE_CLEAR_DONE_IN) begin
                    next_state = flash_seq_pkg::S_ERASE;
                end
            end
            flash_seq_pkg::S_ERASE: next_state = flash_seq_pkg::S_FINISH;
            flash_seq_pkg::S_FINISH: next_state = flash_seq_pkg::S_IDLE;
            default: next_state = flash_seq_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state <= flash_seq_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Command latch; a rejected write still reports through FINISH
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            pend_cmd <= 6'h00;
        end else if (cmd_wr && state == flash_seq_pkg::S_IDLE) begin
            pend_cmd <= cmd_accept ? wr_code : 6'h00;
        end
    end

    // Command register write in IDLE wins over a page buffer write in the same cycle
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            target_page_number <= '0;
            pb_secure <= 1'b0;
        end else if (cmd_wr && state == flash_seq_pkg::S_IDLE) begin
            target_page_number <= AVS_WRITEDATA_IN[PAGE_BITS+7:8];
        end else if (pb_fire) begin
            target_page_number <= pb_page;
            pb_secure <= HSB_SECURE_IN;
        end
    end

    // No reset: contents survive page writes and only the clear command sets ones
    always_ff @(posedge CLK_IN) begin
        if (start && !lock_refuse && pend_cmd == `CMD_CLEAR_PB) begin
            for (int i = 0; i < `PB_WORDS; i++) begin
                page_buffer[i] <= 32'hffffffff;
            end
        end else if (pb_fire) begin
            page_buffer[pb_idx] <= page_buffer[pb_idx] & HSB_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            hsb_cnt <= 3'h0;
        end else if (HSB_READY_OUT) begin
            hsb_cnt <= 3'h0;
        end else if (HSB_VALID_IN && !busy) begin
            hsb_cnt <= hsb_cnt + 3'h1;
        end
    end

    // Reads always come from the array; the page buffer has no read path
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            FLASH_RD_ADDR_OUT <= '0;
            HSB_RDATA_OUT <= 32'h00000000;
        end else if (HSB_VALID_IN && !HSB_WRITE_IN && !busy) begin
            if (hsb_cnt == 3'h0) begin
                FLASH_RD_ADDR_OUT <= HSB_ADDR_IN;
            end
            if (hsb_cnt == 3'h1) begin
                HSB_RDATA_OUT <= FLASH_RD_DATA_IN;
            end
        end
    end

    // Page programming streams one word per cycle
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            prog_idx <= 6'h00;
            FLASH_WR_EN_OUT <= 1'b0;
            FLASH_WR_PAGE_OUT <= '0;
            FLASH_WR_INDEX_OUT <= 6'h00;
            FLASH_WR_DATA_OUT <= 32'h00000000;
        end else begin
            FLASH_WR_EN_OUT <= state == flash_seq_pkg::S_PROG;
            prog_idx <= (state == flash_seq_pkg::S_PROG) ? prog_idx + 6'h01 : 6'h00;
            if (state == flash_seq_pkg::S_PROG) begin
                FLASH_WR_PAGE_OUT <= target_page_number;
                FLASH_WR_INDEX_OUT <= prog_idx;
                FLASH_WR_DATA_OUT <= page_buffer[prog_idx];
            end
        end
    end

    // Erase pulse covers the flash array; lock fuses and secure regions are inputs it leaves alone
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            VOLATILE_CLEAR_REQ_OUT <= 1'b0;
            FLASH_ERASE_ALL_OUT <= 1'b0;
        end else begin
            VOLATILE_CLEAR_REQ_OUT <= next_state == flash_seq_pkg::S_VOLCLR;
            FLASH_ERASE_ALL_OUT <= next_state == flash_seq_pkg::S_ERASE;
        end
    end

    // Status flags; a set in the cycle of a status read wins over its clear
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '{programming_error_flag: 1'b0, lock_violation_flag: 1'b0, ready: 1'b1};
            done_event <= 1'b0;
        end else begin
            flags.programming_error_flag <= programming_error_flag_set | (flags.programming_error_flag & ~status_rd);
            flags.lock_violation_flag <= lock_refuse | (flags.lock_violation_flag & ~status_rd);
            if (state == flash_seq_pkg::S_FINISH) begin
                flags.ready <= 1'b1;
            end else if (cmd_wr && state == flash_seq_pkg::S_IDLE) begin
                flags.ready <= 1'b0;
            end
            done_event <= done_set | (done_event & ~status_rd & ~cmd_wr);
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= (flash_control_reg.ready_ie & (done_event | done_set))
                     | (flash_control_reg.lock_ie & (flags.lock_violation_flag | lock_refuse));
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            flash_control_reg <= `RST_CTRL;
        end else if (ctrl_wr) begin
            flash_control_reg <= {AVS_WRITEDATA_IN[`BIT_LOCK_VIOLATION_FLAG], AVS_WRITEDATA_IN[`BIT_READY]};
        end
    end

    // One wait cycle on every register access; unmapped reads give zero
    assign AVS_WAITREQUEST_OUT = av_req & ~av_ack;
    assign read_mux = (AVS_ADDRESS_IN == `OFS_CTRL) ?
                          {29'h0, flash_control_reg.lock_ie, 1'b0, flash_control_reg.ready_ie} :
                      (AVS_ADDRESS_IN == `OFS_CMD) ?
                          {8'h00, (16)'(target_page_number), 2'b00, pend_cmd} :
                      (AVS_ADDRESS_IN == `OFS_STATUS) ?
                          {28'h0, flags.programming_error_flag, flags.lock_violation_flag, 1'b0, flags.ready} : 32'h00000000;

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            av_ack <= 1'b0;
            AVS_READDATA_OUT <= 32'h00000000;
        end else begin
            av_ack <= av_req & ~av_ack;
            if (AVS_READ_IN && !av_ack) begin
                AVS_READDATA_OUT <= read_mux;
            end
        end
    end

    a_pb_wait_states: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        pb_fire |-> $past(hsb_cnt) == 3'h3 && $past(HSB_VALID_IN, 4))
        else $error("page buffer write answered without four wait states");

    a_pb_and_store: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        pb_fire && !start |=> page_buffer[$past(pb_idx)] == ($past(page_buffer[pb_idx])
                                                             & $past(HSB_WDATA_IN)))
        else $error("page buffer write did not store the AND");

    a_page_from_addr: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        pb_fire && !cmd_wr |=> target_page_number == $past(pb_page))
        else $error("target page not loaded from buffer address");

    a_ready_cycle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        cmd_wr && state == flash_seq_pkg::S_IDLE |=> !flags.ready ##[1:70] flags.ready)
        else $error("ready flag did not drop and return");

    a_ready_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        flags.ready == (state == flash_seq_pkg::S_IDLE))
        else $error("ready flag disagrees with sequencer state");

    // Helper for the checks below: words streamed since the command began
    logic [6:0] wr_words;
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            wr_words <= 7'h00;
        end else if (state == flash_seq_pkg::S_PEND) begin
            wr_words <= 7'h00;
        end else if (FLASH_WR_EN_OUT) begin
            wr_words <= wr_words + 7'h01;
        end
    end

    a_whole_page: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        $fell(FLASH_WR_EN_OUT) |-> wr_words == 7'h40)
        else $error("page write did not stream the whole buffer");

    a_word_order: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        FLASH_WR_EN_OUT |-> FLASH_WR_INDEX_OUT == wr_words[5:0])
        else $error("page write streamed words out of order");

    a_read_stalled: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        busy |-> !(HSB_READY_OUT && !HSB_WRITE_IN))
        else $error("flash read answered during a command");

    a_start_on_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        state == flash_seq_pkg::S_PEND && !hsb_idle |=> state == flash_seq_pkg::S_PEND)
        else $error("command started while bus interface busy");

    a_busy_programming_error_flag: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        cmd_wr && state != flash_seq_pkg::S_IDLE |=> flags.programming_error_flag && $stable(pend_cmd))
        else $error("command during execution not flagged");

    a_badkey_programming_error_flag: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        cmd_wr && !key_ok |=> flags.programming_error_flag && state != flash_seq_pkg::S_PEND)
        else $error("bad key accepted");

    a_erase_refused: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        start && pend_cmd == `CMD_ERASE_ALL && any_lock
            |=> flags.lock_violation_flag && !VOLATILE_CLEAR_REQ_OUT ##1 !FLASH_ERASE_ALL_OUT)
        else $error("erase all ran with a lock set");

    a_volatile_first: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        $rose(FLASH_ERASE_ALL_OUT) |-> $past(VOLATILE_CLEAR_REQ_OUT))
        else $error("erase before volatile clear");

    a_flags_cleared: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        status_rd && !programming_error_flag_set && !lock_refuse |=> !flags.programming_error_flag && !flags.lock_violation_flag)
        else $error("status read did not clear error flags");

    a_lock_irq: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        lock_refuse && flash_control_reg.lock_ie |=> IRQ_OUT)
        else $error("lock error did not raise interrupt");
endmodule : flash_page_program_sequencer
`default_nettype wire

// ---- tb/flash_array_model.sv ----
// Flash array and volatile-memory stand-in at the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
    parameter int PAGE_BITS = 6
) (
    input wire logic clk_in,
    input wire logic [PAGE_BITS+5:0] rd_addr_in,
    output logic [31:0] rd_data_out,
    input wire logic wr_en_in,
    input wire logic [PAGE_BITS-1:0] wr_page_in,
    input wire logic [5:0] wr_index_in,
    input wire logic [31:0] wr_data_in,
    input wire logic erase_all_in,
    input wire logic clear_req_in,
    output logic clear_done_out,
    output var int n_wr_out,
    output var int n_erase_out,
    output var int n_bad_order_out
);
    logic [31:0] mem [0:(2**(PAGE_BITS+6))-1];
    logic cleared;
    int wait_cnt;
    // Array reads are asynchronous, as the sequencer expects
    assign rd_data_out = mem[rd_addr_in];
    initial begin
        foreach (mem[i]) mem[i] = 32'hffff_ffff;
        n_wr_out = 0;
        n_erase_out = 0;
        n_bad_order_out = 0;
        cleared = 1'b0;
        wait_cnt = 0;
        clear_done_out = 1'b0;
    end
    always @(posedge clk_in) begin
        // Programming can only clear bits, like real cells
        if (wr_en_in) begin
            mem[{wr_page_in, wr_index_in}] <= mem[{wr_page_in, wr_index_in}] & wr_data_in;
            n_wr_out <= n_wr_out + 1;
        end
        if (erase_all_in) begin
            foreach (mem[i]) mem[i] <= 32'hffff_ffff;
            n_erase_out <= n_erase_out + 1;
            n_bad_order_out <= n_bad_order_out + (cleared ? 0 : 1);
            cleared <= 1'b0;
        end else if (clear_req_in && clear_done_out) begin
            cleared <= 1'b1;
        end
        // Slow answer: the clear takes several cycles
        wait_cnt <= clear_req_in ? wait_cnt + 1 : 0;
        clear_done_out <= clear_req_in && (wait_cnt >= 5);
    end
endmodule : flash_array_model
`default_nettype wire

// ---- tb/test_flash_page_program_sequencer.sv ----
// Self-checking bench of the flash page program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_params.svh"
module test_flash_page_program_sequencer;
    logic clk, rstn, av_rd, av_wr, wreq, hs_valid, hs_write, hs_sec, hs_ready, irq;
    logic [3:0] av_addr;
    logic [31:0] av_wdata, rdata, hs_wdata, hs_rdata, fl_rdata, wr_data;
    logic [11:0] hs_addr, rd_addr;
    logic [15:0] lock, secreg;
    logic [2:0] boot;
    logic wr_en, erase, clr_req, clr_done;
    logic [5:0] wr_page, wr_idx;
    int n_wr, n_erase, n_bad, errors, n_tests;
    flash_page_program_sequencer #(.PAGE_BITS(6)) flash_page_program_sequencer_inst (
        .CLK_IN(clk), .RSTN_IN(rstn), .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd),
        .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wdata), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wreq), .HSB_VALID_IN(hs_valid), .HSB_WRITE_IN(hs_write),
        .HSB_ADDR_IN(hs_addr), .HSB_WDATA_IN(hs_wdata), .HSB_SECURE_IN(hs_sec),
        .HSB_READY_OUT(hs_ready), .HSB_RDATA_OUT(hs_rdata), .FLASH_RD_ADDR_OUT(rd_addr),
        .FLASH_RD_DATA_IN(fl_rdata), .FLASH_WR_EN_OUT(wr_en), .FLASH_WR_PAGE_OUT(wr_page),
        .FLASH_WR_INDEX_OUT(wr_idx), .FLASH_WR_DATA_OUT(wr_data), .FLASH_ERASE_ALL_OUT(erase),
        .VOLATILE_CLEAR_REQ_OUT(clr_req), .VOLATILE_CLEAR_DONE_IN(clr_done),
        .LOCK_FUSES_IN(lock), .BOOT_AREA_PROTECT_FUSES_IN(boot),
        .SECURE_REGIONS_IN(secreg), .IRQ_OUT(irq));
    flash_array_model #(.PAGE_BITS(6)) flash_array_model_inst (
        .clk_in(clk), .rd_addr_in(rd_addr), .rd_data_out(fl_rdata), .wr_en_in(wr_en),
        .wr_page_in(wr_page), .wr_index_in(wr_idx), .wr_data_in(wr_data),
        .erase_all_in(erase), .clear_req_in(clr_req), .clear_done_out(clr_done),
        .n_wr_out(n_wr), .n_erase_out(n_erase), .n_bad_order_out(n_bad));
    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        bit ok;
        ok = 0;
        av_addr <= a; av_wr <= wr; av_rd <= !wr; av_wdata <= d;
        for (int k = 0; k < 50 && !ok; k++) begin
            #1;
            ok = (wreq === 1'b0);
            q = rdata;
            @(posedge clk);
        end
        av_wr <= 1'b0; av_rd <= 1'b0;
        if (!ok) begin
            chk("register bus answer", 32'h1, 32'h0);
            end_of_test();
        end
        @(posedge clk);
    endtask : av
    // Full aligned words only; masters never issue narrow writes
    task automatic high_speed_bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic sec, output logic [31:0] q, output int w);
        bit ok;
        ok = 0;
        w = 0;
        hs_valid <= 1'b1; hs_write <= wr; hs_addr <= a; hs_wdata <= d; hs_sec <= sec;
        for (int k = 0; k < 500 && !ok; k++) begin
            #1;
            ok = (hs_ready === 1'b1);
            q = hs_rdata;
            @(posedge clk);
            w += ok ? 0 : 1;
        end
        hs_valid <= 1'b0;
        if (!ok) begin
            chk("high speed bus answer", 32'h1, 32'h0);
            end_of_test();
        end
        @(posedge clk);
    endtask : high_speed_bus
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask : wr_reg
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask : rd_chk
    task automatic pb_wr(input logic [5:0] pg, input logic [5:0] ix, input logic [31:0] d,
                         input logic sec);
        logic [31:0] q;
        int w;
        high_speed_bus(1'b1, {pg, ix}, d, sec, q, w);
        chk("buffer write waits", 32'h4, w);
    endtask : pb_wr
    task automatic fl_rd(input logic [5:0] pg, input logic [5:0] ix, input logic [31:0] exp);
        logic [31:0] q;
        int w;
        high_speed_bus(1'b0, {pg, ix}, 32'h0, 1'b0, q, w);
        chk("flash read", exp, q);
    endtask : fl_rd
    function automatic logic [31:0] cmdw(input logic [5:0] code, input logic [5:0] pg);
        return {`CMD_KEY, 10'h0, pg, 2'h0, code};
    endfunction : cmdw
    // The stalled read doubles as the wait for command completion
    task automatic run_cmd(input logic [31:0] word, input logic [31:0] st, input logic ie);
        wr_reg(`OFS_CMD, word);
        @(posedge clk);
        fl_rd(6'd7, 6'd0, 32'hffff_ffff);
        chk("irq", {31'h0, ie}, {31'h0, irq});
        rd_chk("status", `OFS_STATUS, st);
    endtask : run_cmd
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        errors = 0; n_tests = 0; rstn = 1'b0; av_rd = 1'b0; av_wr = 1'b0; av_addr = 4'h0;
        av_wdata = 32'h0; hs_valid = 1'b0; hs_write = 1'b0; hs_addr = 12'h0;
        hs_wdata = 32'h0; hs_sec = 1'b0; lock = 16'hffff; boot = 3'h0; secreg = 16'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk("status", `OFS_STATUS, 32'h1);
        rd_chk("control", `OFS_CTRL, 32'h0);
        rd_chk("unmapped", 4'hc, 32'h0);
        run_cmd(cmdw(`CMD_CLEAR_PB, 6'd0), 32'h1, 1'b0);
        pb_wr(6'd5, 6'd0, 32'h1234_5678, 1'b1);
        pb_wr(6'd5, 6'd0, 32'hffff_00ff, 1'b1);
        pb_wr(6'd5, 6'h3f, 32'ha5a5_a5a5, 1'b1);
        rd_chk("page field", `OFS_CMD, 32'h0000_0503);
        wr_reg(`OFS_CTRL, 32'h1);
        wr_reg(`OFS_CMD, cmdw(`CMD_WRITE_PAGE, 6'd5));
        rd_chk("busy status", `OFS_STATUS, 32'h0);
        wr_reg(`OFS_CMD, cmdw(`CMD_WRITE_PAGE, 6'd9));
        fl_rd(6'd5, 6'd0, 32'h1234_0078);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk("status", `OFS_STATUS, 32'h9);
        rd_chk("status", `OFS_STATUS, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        fl_rd(6'd5, 6'h3f, 32'ha5a5_a5a5);
        fl_rd(6'd7, 6'd0, 32'hffff_ffff);
        chk("words programmed", 32'd64, n_wr);
        run_cmd(cmdw(`CMD_WRITE_PAGE, 6'd6), 32'h1, 1'b1);
        fl_rd(6'd6, 6'h3f, 32'ha5a5_a5a5);
        fl_rd(6'd6, 6'd0, 32'h1234_0078);
        // Command lands while a read is in flight; it must wait for the idle cycle
        fork
            fl_rd(6'd6, 6'h3f, 32'ha5a5_a5a5);
            wr_reg(`OFS_CMD, cmdw(`CMD_CLEAR_PB, 6'd0));
        join
        rd_chk("page field", `OFS_CMD, 32'h0000_0003);
        wr_reg(`OFS_CTRL, 32'h0);
        run_cmd(32'h5a00_0001, 32'h9, 1'b0);
        run_cmd(cmdw(6'h3f, 6'd0), 32'h9, 1'b0);
        chk("words programmed", 32'd128, n_wr);
        wr_reg(`OFS_CTRL, 32'h1);
        run_cmd(cmdw(`CMD_QUICK_CHECK, 6'd0), 32'h1, 1'b0);
        wr_reg(`OFS_CTRL, 32'h4);
        lock <= 16'hfff7;
        run_cmd(cmdw(`CMD_WRITE_PAGE, 6'd13), 32'h5, 1'b1);
        run_cmd(cmdw(`CMD_ERASE_ALL, 6'd0), 32'h5, 1'b1);
        lock <= 16'hffff;
        boot <= 3'h2;
        run_cmd(cmdw(`CMD_WRITE_PAGE, 6'd2), 32'h5, 1'b1);
        run_cmd(cmdw(`CMD_ERASE_ALL, 6'd0), 32'h5, 1'b1);
        boot <= 3'h0;
        chk("erase pulses", 32'd0, n_erase);
        wr_reg(`OFS_CTRL, 32'h0);
        secreg <= 16'h0010;
        pb_wr(6'd17, 6'd1, 32'h0, 1'b0);
        run_cmd(cmdw(`CMD_WRITE_PAGE, 6'd17), 32'h5, 1'b0);
        chk("words programmed", 32'd128, n_wr);
        pb_wr(6'd17, 6'd1, 32'h0, 1'b1);
        run_cmd(cmdw(`CMD_WRITE_PAGE, 6'd17), 32'h1, 1'b0);
        fl_rd(6'd17, 6'd1, 32'h0);
        run_cmd(cmdw(`CMD_ERASE_ALL, 6'd0), 32'h1, 1'b0);
        chk("erase pulses", 32'd1, n_erase);
        chk("erase before clear", 32'd0, n_bad);
        fl_rd(6'd17, 6'd1, 32'hffff_ffff);
        end_of_test();
    end
endmodule : test_flash_page_program_sequencer
`default_nettype wire
